// ===== design/clk_src_pkg.sv
// Package of constants and types for the CPU clock-source control block.
package clk_src_pkg;

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] OSC_MODE_ADDR     = 8'hA0;
  localparam logic [7:0] MAIN_CTRL_ADDR    = 8'hA1;
  localparam logic [7:0] CLK_SEL_ADDR      = 8'hA2;
  localparam logic [7:0] STAB_STATUS_ADDR  = 8'hA3;
  localparam logic [7:0] STAB_SELECT_ADDR  = 8'hA4;
  localparam logic [7:0] SUB_CTRL_ADDR     = 8'hA5;
  localparam logic [7:0] SET_BIT_ADDR      = 8'hA6;
  localparam logic [7:0] CLR_BIT_ADDR      = 8'hA7;
  localparam logic [7:0] STATUS_ADDR       = 8'hA8;
  localparam logic [7:0] CFG_ADDR          = 8'hA9;

  // ----------------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------------
  localparam int HS_STABLE_BIT  = 7;
  localparam int LS_STOP_BIT    = 1;
  localparam int HS_STOP_BIT    = 0;
  localparam int MAIN_STOP_BIT  = 7;
  localparam int PIN_SEL_BIT    = 6;
  localparam int EXT_CLK_BIT    = 4;
  localparam logic [7:0] OSC_MODE_RST    = 8'h00;
  localparam logic [7:0] OSC_MODE_STABLE = 8'h80;
  localparam logic [7:0] MAIN_CTRL_RST   = 8'h80;
  localparam logic [2:0] STAB_SELECT_RST = 3'h5;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 25;
  localparam int HS_SETTLE_NS    = 2000;
  localparam int HS_SETTLE_CYC   = (HS_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STAB_CNT_W      = 18;
  localparam int STAB_CODES      = 8;

  typedef enum logic [1:0] {
    SRC_HS_INT,
    SRC_MAIN_EXT,
    SRC_SUB
  } cpu_src_e;

  typedef logic [STAB_CNT_W-1:0] stab_cnt_t;

  // Stabilisation length in oscillator edges for a select code: 2^(11+code) for codes 0 to 3, 2^(10+code) for codes 4 to 7.
  function automatic stab_cnt_t stab_len(input logic [2:0] code);
    stab_len = stab_cnt_t'(1) << (11 + code[1:0] + (code[2] ? 3 : 0));
  endfunction : stab_len

endpackage : clk_src_pkg

// ===== design/stab_if.sv
// Interface carrying the oscillator stabilisation request and status.
`timescale 1ns/1ps
interface stab_if;
  logic                   start;
  logic                   run;
  logic [2:0]             sel;
  logic [7:0]             status;
  logic                   done;

  modport ctrl (output start, output run, output sel, input status, input done);
  modport cnt  (input start, input run, input sel, output status, output done);
endinterface : stab_if

// ===== design/stab_counter.sv
// Oscillation stabilisation counter with a thermometer status byte.
`timescale 1ns/1ps
module stab_counter (
  input  wire logic i_clk,   // System clock.
  input  wire logic i_nrst,  // Async reset, active low.
  input  wire logic i_tick,  // One oscillator edge seen.
  stab_if.cnt       bus      // Request and status.
);
  import clk_src_pkg::*;

  typedef struct packed {
    stab_cnt_t   cnt;
    logic [7:0]  status;
    logic        done;
  } st_s;

  st_s s_q;
  st_s s_d;

  always_comb begin
    s_d = s_q;
    if (!bus.run || bus.start) begin
      s_d = '0;
    end else if (!s_q.done && i_tick) begin
      s_d.cnt = s_q.cnt + stab_cnt_t'(1);
      for (int k = 0; k < STAB_CODES; k++) begin
        if (s_d.cnt >= stab_len(3'(k))) begin
          s_d.status[7-k] = 1'b1;
        end
      end
      if (s_d.cnt >= stab_len(bus.sel)) begin
        s_d.done = 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign bus.status = s_q.status;
  assign bus.done   = s_q.done;
endmodule : stab_counter

// ===== design/hs_settle.sv
// Settling timer for the internal high-speed oscillator accuracy.
`timescale 1ns/1ps
module hs_settle (
  input  wire logic i_clk,     // System clock.
  input  wire logic i_nrst,    // Async reset, active low.
  input  wire logic i_run,     // Oscillator enabled.
  output logic      o_stable   // Accuracy reached.
);
  import clk_src_pkg::*;

  typedef struct packed {
    logic [15:0] cnt;
    logic        stable;
  } st_s;

  st_s s_q;
  st_s s_d;

  always_comb begin
    s_d = s_q;
    if (!i_run) begin
      s_d = '0;
    end else if (s_q.cnt == 16'(HS_SETTLE_CYC - 1)) begin
      s_d.stable = 1'b1;
    end else begin
      s_d.cnt = s_q.cnt + 16'h0001;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_stable = s_q.stable;
endmodule : hs_settle

// ===== design/cpu_clock_source_control.sv
// Top of the CPU clock-source control block with its register port.
//
// Chosen here: strobed register access and the placing of the registers.
`timescale 1ns/1ps
module cpu_clock_source_control (
  input  wire logic       I_CLK_SYS,     // System clock, 40 MHz.
  input  wire logic       I_NRST,        // Async reset, active low.
  input  wire logic [7:0] I_ADDR,        // Register address.
  input  wire logic [7:0] I_WDATA,       // Write data.
  input  wire logic       I_WR,          // Write strobe.
  input  wire logic       I_RD,          // Read strobe.
  input  wire logic       I_LS_STOP_OK,  // Option: low-speed stop allowed.
  input  wire logic       I_MAIN_TICK,   // Main crystal edge seen.
  input  wire logic       I_SUB_TICK,    // Sub crystal edge seen.
  input  wire logic       I_STOP_EXIT,   // STOP mode release pulse.
  output logic      [7:0] O_RDATA,       // Read data.
  output logic            O_HS_RUN,      // Internal high-speed osc enable.
  output logic            O_LS_RUN,      // Internal low-speed osc enable.
  output logic            O_MAIN_RUN,    // Main crystal or ext input enable.
  output logic            O_EXT_SEL,     // Main comes from external pin.
  output logic            O_SUB_RUN,     // Sub crystal enable.
  output logic      [1:0] O_CPU_SRC,     // Selected CPU clock source.
  output logic            O_CPU_READY    // CPU clock usable after STOP.
);
  import clk_src_pkg::*;

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic       hs_stop;
    logic       ls_stop;
    logic       main_stop;
    logic       pin_sel;
    logic       ext_clk;
    logic       main_sel;
    logic       sub_sel;
    logic       sub_osc;
    logic [2:0] stab_sel;
    logic       stop_wait;
    logic       sub_ok;
    logic [11:0] sub_cnt;
    logic       sub_done;
    logic [7:0] rdata;
    logic       hs_run;
    logic       ls_run;
    logic       main_run;
    logic       ext_sel;
    logic       sub_run;
    cpu_src_e   cpu_src;
    logic       cpu_ready;
  } st_s;

  st_s s_q;
  st_s s_d;

  logic hs_stable;
  logic [7:0] mode_val;
  logic [7:0] wr_mode;

  stab_if stab ();

  // ----------------------------------------------------------------------
  // Sub-blocks
  // ----------------------------------------------------------------------
  hs_settle u_hs_settle (
    .i_clk    (I_CLK_SYS),
    .i_nrst   (I_NRST),
    .i_run    (!s_q.hs_stop),
    .o_stable (hs_stable)
  );

  stab_counter u_stab_counter (
    .i_clk  (I_CLK_SYS),
    .i_nrst (I_NRST),
    .i_tick (I_MAIN_TICK),
    .bus    (stab.cnt)
  );

  // Counter restarts when the crystal starts or when STOP is released.
  assign stab.run   = !s_q.main_stop && !s_q.ext_clk && s_q.pin_sel;
  assign stab.start = I_STOP_EXIT || (s_q.main_stop && !s_d.main_stop);
  assign stab.sel   = s_q.stab_sel;

  // ----------------------------------------------------------------------
  // Register view
  // ----------------------------------------------------------------------
  always_comb begin
    mode_val = OSC_MODE_RST;
    mode_val[HS_STABLE_BIT] = hs_stable;
    mode_val[LS_STOP_BIT]   = s_q.ls_stop;
    mode_val[HS_STOP_BIT]   = s_q.hs_stop;
  end

  // Single-bit set and clear ports model bit manipulation on the mode register.
  always_comb begin
    wr_mode = mode_val;
    if (I_ADDR == OSC_MODE_ADDR) begin
      wr_mode = I_WDATA;
    end else if (I_ADDR == SET_BIT_ADDR) begin
      wr_mode = mode_val | (8'h01 << I_WDATA[2:0]);
    end else if (I_ADDR == CLR_BIT_ADDR) begin
      wr_mode = mode_val & ~(8'h01 << I_WDATA[2:0]);
    end
  end

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.rdata = 8'h00;
    // Sub crystal settling: a latch after a fixed tick count is enough here.
    if (!s_q.sub_osc) begin
      s_d.sub_cnt  = 12'h000;
      s_d.sub_done = 1'b0;
    end else if (I_SUB_TICK && !s_q.sub_done) begin
      s_d.sub_cnt  = s_q.sub_cnt + 12'h001;
      s_d.sub_done = (s_q.sub_cnt == 12'hFFF);
    end
    s_d.sub_ok = s_q.sub_done;

    if (I_WR) begin
      unique case (I_ADDR)
        OSC_MODE_ADDR, SET_BIT_ADDR, CLR_BIT_ADDR: begin
          s_d.hs_stop = wr_mode[HS_STOP_BIT];
          s_d.ls_stop = wr_mode[LS_STOP_BIT] && I_LS_STOP_OK;
        end
        MAIN_CTRL_ADDR: begin
          s_d.main_stop = I_WDATA[MAIN_STOP_BIT];
          s_d.pin_sel   = I_WDATA[PIN_SEL_BIT];
          s_d.ext_clk   = I_WDATA[EXT_CLK_BIT];
        end
        CLK_SEL_ADDR: begin
          s_d.main_sel = I_WDATA[0];
          s_d.sub_sel  = I_WDATA[4];
        end
        STAB_SELECT_ADDR: s_d.stab_sel = I_WDATA[2:0];
        SUB_CTRL_ADDR:    s_d.sub_osc  = I_WDATA[0];
        default: ;
      endcase
    end

    if (I_RD) begin
      unique case (I_ADDR)
        OSC_MODE_ADDR:    s_d.rdata = mode_val;
        MAIN_CTRL_ADDR:   s_d.rdata = {s_q.main_stop, s_q.pin_sel, 1'b0, s_q.ext_clk, 4'h0};
        CLK_SEL_ADDR:     s_d.rdata = {3'h0, s_q.sub_sel, 3'h0, s_q.main_sel};
        STAB_STATUS_ADDR: s_d.rdata = stab.status;
        STAB_SELECT_ADDR: s_d.rdata = {5'h00, s_q.stab_sel};
        SUB_CTRL_ADDR:    s_d.rdata = {7'h00, s_q.sub_osc};
        STATUS_ADDR:      s_d.rdata = {s_q.cpu_ready, s_q.sub_ok, stab.done, 3'h0,
                                       2'(s_q.cpu_src)};
        CFG_ADDR:         s_d.rdata = {7'h00, I_LS_STOP_OK};
        default:          s_d.rdata = 8'h00;
      endcase
    end

    // Source selection; software is trusted to obey the switching conditions.
    if (s_q.sub_sel) begin
      s_d.cpu_src = SRC_SUB;
    end else if (s_q.main_sel) begin
      s_d.cpu_src = SRC_MAIN_EXT;
    end else begin
      s_d.cpu_src = SRC_HS_INT;
    end

    // After STOP release the CPU waits for its clock to be usable.
    if (I_STOP_EXIT) begin
      s_d.stop_wait = 1'b1;
    end else if (s_q.stop_wait) begin
      unique case (s_q.cpu_src)
        SRC_HS_INT:   s_d.stop_wait = !hs_stable;
        SRC_MAIN_EXT: s_d.stop_wait = !(s_q.ext_clk || stab.done);
        SRC_SUB:      s_d.stop_wait = !s_q.sub_ok;
        default:      s_d.stop_wait = 1'b0;
      endcase
    end
    s_d.cpu_ready = !s_d.stop_wait && (hs_stable || s_q.cpu_src != SRC_HS_INT);

    s_d.hs_run   = !s_q.hs_stop;
    s_d.ls_run   = !(s_q.ls_stop && I_LS_STOP_OK);
    s_d.main_run = !s_q.main_stop && s_q.pin_sel;
    s_d.ext_sel  = s_q.ext_clk;
    s_d.sub_run  = s_q.sub_osc;
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST) begin
      s_q           <= '0;
      s_q.main_stop <= MAIN_CTRL_RST[MAIN_STOP_BIT];
      s_q.stab_sel  <= STAB_SELECT_RST;
      s_q.hs_run    <= 1'b1;
      s_q.ls_run    <= 1'b1;
      s_q.cpu_src   <= SRC_HS_INT;
    end else begin
      s_q <= s_d;
    end
  end

  assign O_RDATA     = s_q.rdata;
  assign O_HS_RUN    = s_q.hs_run;
  assign O_LS_RUN    = s_q.ls_run;
  assign O_MAIN_RUN  = s_q.main_run;
  assign O_EXT_SEL   = s_q.ext_sel;
  assign O_SUB_RUN   = s_q.sub_run;
  assign O_CPU_SRC   = 2'(s_q.cpu_src);
  assign O_CPU_READY = s_q.cpu_ready;
endmodule : cpu_clock_source_control

// ===== test/clk_src_monitor.sv
// Checker of the clock-source control block at its top-level ports.
`timescale 1ns/1ps
module clk_src_monitor
  import clk_src_pkg::*;
(
  input wire logic       I_CLK_SYS,    // Clock.
  input wire logic       I_NRST,       // Reset.
  input wire logic [7:0] I_ADDR,       // Address.
  input wire logic [7:0] I_WDATA,      // Write data.
  input wire logic       I_WR,         // Write.
  input wire logic       I_RD,         // Read.
  input wire logic       I_LS_STOP_OK, // Option.
  input wire logic       I_MAIN_TICK,  // Main tick.
  input wire logic       I_SUB_TICK,   // Sub tick.
  input wire logic       I_STOP_EXIT,  // STOP release.
  input wire logic [7:0] O_RDATA,      // Read data.
  input wire logic       O_HS_RUN,     // HS enable.
  input wire logic       O_LS_RUN,     // LS enable.
  input wire logic       O_MAIN_RUN,   // Main enable.
  input wire logic       O_EXT_SEL,    // External pin.
  input wire logic       O_SUB_RUN,    // Sub enable.
  input wire logic [1:0] O_CPU_SRC,    // CPU source.
  input wire logic       O_CPU_READY   // CPU ready.
);
  logic [7:0] cyc_q;  // Cycles since reset release, saturating.
  always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST) cyc_q <= 8'h00;
    else if (cyc_q != 8'hFF) cyc_q <= cyc_q + 8'h01;
  end
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_NRST);
  // ----
  // Assertions
  // ----
  chk_rd_idle: assert property (!$past(I_RD) |-> O_RDATA == 8'h00)
    else $error("read data not zero outside read cycle");
  chk_mode_zeros: assert property ($past(I_RD) && $past(I_ADDR) == OSC_MODE_ADDR
    |-> O_RDATA[6:2] == 5'h00) else $error("mode register unused bits set");
  chk_early_wait: assert property (cyc_q < 8'd60 && $past(I_RD)
    && $past(I_ADDR) == OSC_MODE_ADDR |-> !O_RDATA[HS_STABLE_BIT])
    else $error("stable bit set too early");
  chk_hs_start: assert property (!$past(I_NRST) |-> O_HS_RUN && O_LS_RUN
    && O_CPU_SRC == 2'h0) else $error("oscillator not started on reset release");
  chk_hs_stop: assert property (I_WR && I_ADDR == OSC_MODE_ADDR ##1 !I_WR
    |=> O_HS_RUN == !$past(I_WDATA[HS_STOP_BIT], 2)) else $error("hs run wrong");
  chk_ls_stop: assert property (I_WR && I_ADDR == OSC_MODE_ADDR ##1 !I_WR
    |=> O_LS_RUN == !($past(I_WDATA[LS_STOP_BIT], 2) && $past(I_LS_STOP_OK, 2)))
    else $error("ls run wrong");
  chk_ext_nowait: assert property (I_STOP_EXIT && O_EXT_SEL && O_CPU_SRC == 2'h1
    |-> ##[1:2] O_CPU_READY) else $error("external clock waited");
  chk_xtal_wait: assert property (I_STOP_EXIT && !O_EXT_SEL && O_CPU_SRC == 2'h1
    |-> ##2 !O_CPU_READY [*8]) else $error("crystal ready without wait");
  cov_ext: cover property (I_STOP_EXIT && O_EXT_SEL);
  cov_xtal: cover property (I_STOP_EXIT && !O_EXT_SEL && O_CPU_SRC == 2'h1);
  cov_sub: cover property (O_CPU_SRC == 2'h2);
endmodule : clk_src_monitor

bind cpu_clock_source_control clk_src_monitor i_mon (
  .I_CLK_SYS(I_CLK_SYS), .I_NRST(I_NRST), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR),
  .I_RD(I_RD), .I_LS_STOP_OK(I_LS_STOP_OK), .I_MAIN_TICK(I_MAIN_TICK),
  .I_SUB_TICK(I_SUB_TICK), .I_STOP_EXIT(I_STOP_EXIT), .O_RDATA(O_RDATA), .O_HS_RUN(O_HS_RUN),
  .O_LS_RUN(O_LS_RUN), .O_MAIN_RUN(O_MAIN_RUN), .O_EXT_SEL(O_EXT_SEL), .O_SUB_RUN(O_SUB_RUN),
  .O_CPU_SRC(O_CPU_SRC), .O_CPU_READY(O_CPU_READY));

// ===== test/cpu_clock_source_control_tb.sv
// Self-checking testbench of the CPU clock-source control block.
`timescale 1ns/1ps
module cpu_clock_source_control_tb;
  import clk_src_pkg::*;
  logic       clk_sys = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0, ls_ok = 1'b0;
  logic       main_tick = 1'b0, sub_tick = 1'b0, stop_exit = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
  logic       hs_run, ls_run, main_run, ext_sel, sub_run, cpu_ready;
  logic [1:0] cpu_src;
  int         n_errors = 0, checks_done = 0, waited;
  always #12.5 clk_sys = ~clk_sys;
  cpu_clock_source_control i_dut (
    .I_CLK_SYS(clk_sys), .I_NRST(nrst), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr),
    .I_RD(rd), .I_LS_STOP_OK(ls_ok), .I_MAIN_TICK(main_tick), .I_SUB_TICK(sub_tick),
    .I_STOP_EXIT(stop_exit), .O_RDATA(rdata), .O_HS_RUN(hs_run), .O_LS_RUN(ls_run),
    .O_MAIN_RUN(main_run), .O_EXT_SEL(ext_sel), .O_SUB_RUN(sub_run), .O_CPU_SRC(cpu_src),
    .O_CPU_READY(cpu_ready));
  task automatic wrap_up;
    $display("Checks %0d, mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : wrap_up
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask : wr_reg
  // Read data stand only in the cycle after the read edge, so sample just after it.
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e,
                        input string what);
    logic [7:0] v;
    rd_reg(a, v);
    check(what, v & m, e);
  endtask : rd_chk
  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : idle
  task automatic poll(input logic [7:0] a, input int b);
    logic [7:0] v;
    int         n;
    n = 0;
    v = 8'h00;
    while (v[b] !== 1'b1) begin
      if (n == 3000) begin
        n_errors++;
        wrap_up;
      end
      rd_reg(a, v);
      n++;
    end
  endtask : poll
  task automatic pulse_stop;
    @(posedge clk_sys);
    stop_exit <= 1'b1;
    @(posedge clk_sys);
    stop_exit <= 1'b0;
  endtask : pulse_stop
  // ----
  // Sequence
  // ----
  initial begin
    repeat (12) @(posedge clk_sys);
    nrst <= 1'b1;
    rd_chk(OSC_MODE_ADDR, 8'hFF, OSC_MODE_RST, "mode after reset");
    check("hs run after reset", 8'(hs_run), 8'h01);
    check("ls run after reset", 8'(ls_run), 8'h01);
    poll(OSC_MODE_ADDR, HS_STABLE_BIT);
    rd_chk(OSC_MODE_ADDR, 8'hFF, OSC_MODE_STABLE, "mode when stable");
    wr_reg(OSC_MODE_ADDR, 8'h7C);
    rd_chk(OSC_MODE_ADDR, 8'hFF, 8'h80, "stable bit kept");
    wr_reg(OSC_MODE_ADDR, 8'h02);
    rd_chk(OSC_MODE_ADDR, 8'hFF, 8'h80, "ls stop refused");
    check("ls run kept", 8'(ls_run), 8'h01);
    @(posedge clk_sys) ls_ok <= 1'b1;
    rd_chk(CFG_ADDR, 8'hFF, 8'h01, "option bit");
    wr_reg(OSC_MODE_ADDR, 8'h02);
    rd_chk(OSC_MODE_ADDR, 8'hFF, 8'h82, "ls stop taken");
    check("ls run stopped", 8'(ls_run), 8'h00);
    wr_reg(OSC_MODE_ADDR, 8'h00);
    idle(2);
    check("ls run again", 8'(ls_run), 8'h01);
    wr_reg(MAIN_CTRL_ADDR, 8'h50);
    wr_reg(CLK_SEL_ADDR, 8'h01);
    idle(2);
    check("cpu on main", 8'(cpu_src), 8'h01);
    check("ext sel", 8'(ext_sel), 8'h01);
    check("main run", 8'(main_run), 8'h01);
    wr_reg(SET_BIT_ADDR, 8'h00);
    rd_chk(OSC_MODE_ADDR, 8'h01, 8'h01, "hs stop by bit set");
    check("hs run stopped", 8'(hs_run), 8'h00);
    wr_reg(CLR_BIT_ADDR, 8'h00);
    rd_chk(OSC_MODE_ADDR, 8'h01, 8'h00, "hs stop by bit clear");
    check("hs run again", 8'(hs_run), 8'h01);
    poll(OSC_MODE_ADDR, HS_STABLE_BIT);
    pulse_stop;
    idle(2);
    check("ext ready", 8'(cpu_ready), 8'h01);
    @(posedge clk_sys) main_tick <= 1'b1;
    wr_reg(STAB_SELECT_ADDR, 8'h00);
    wr_reg(MAIN_CTRL_ADDR, 8'h40);
    pulse_stop;
    idle(1000);
    check("ready during wait", 8'(cpu_ready), 8'h00);
    rd_chk(STAB_STATUS_ADDR, 8'hFF, 8'h00, "stab status mid");
    waited = 1000;
    while (cpu_ready !== 1'b1 && waited < 3000) begin
      idle(1);
      waited++;
    end
    check("stab wait length", 8'(waited >= 2040 && waited < 3000), 8'h01);
    if (waited == 3000) wrap_up;
    rd_chk(STAB_STATUS_ADDR, 8'hFF, 8'h80, "stab status done");
    @(posedge clk_sys) sub_tick <= 1'b1;
    wr_reg(SUB_CTRL_ADDR, 8'h01);
    poll(STATUS_ADDR, 6);
    wr_reg(CLK_SEL_ADDR, 8'h11);
    idle(2);
    check("cpu on sub", 8'(cpu_src), 8'h02);
    check("sub run", 8'(sub_run), 8'h01);
    wr_reg(CLK_SEL_ADDR, 8'h00);
    idle(2);
    check("cpu back on hs", 8'(cpu_src), 8'h00);
    wr_reg(CLK_SEL_ADDR, 8'h11);
    wr_reg(CLK_SEL_ADDR, 8'h01);
    idle(2);
    check("cpu sub to main", 8'(cpu_src), 8'h01);
    rd_chk(8'h00, 8'hFF, 8'h00, "unmapped read");
    @(posedge clk_sys) nrst <= 1'b0;
    idle(3);
    check("hs run in reset", 8'(hs_run), 8'h01);
    @(posedge clk_sys) nrst <= 1'b1;
    rd_chk(MAIN_CTRL_ADDR, 8'hFF, MAIN_CTRL_RST, "main ctrl reset");
    rd_chk(STAB_SELECT_ADDR, 8'h07, 8'(STAB_SELECT_RST), "stab select reset");
    rd_chk(OSC_MODE_ADDR, 8'hFF, OSC_MODE_RST, "mode after second reset");
    wrap_up;
  end
endmodule : cpu_clock_source_control_tb
